//--- logic/bfev_pkg.sv
// constants and types for the bus fault exception vectoring block
package bfev_pkg;
   // vector numbers
   localparam logic [7:0] VEC_RESET_SSP   = 8'h00;
   localparam logic [7:0] VEC_RESET_PC    = 8'h01;
   localparam logic [7:0] VEC_BUS_ERR     = 8'h02;
   localparam logic [7:0] VEC_ADDR_ERR    = 8'h03;
   localparam logic [7:0] VEC_ILLEGAL     = 8'h04;
   localparam logic [7:0] VEC_ZERO_DIV    = 8'h05;
   localparam logic [7:0] VEC_BOUNDS      = 8'h06;
   localparam logic [7:0] VEC_COND_TRAP   = 8'h07;
   localparam logic [7:0] VEC_PRIV        = 8'h08;
   localparam logic [7:0] VEC_TRACE       = 8'h09;
   localparam logic [7:0] VEC_LINE_A      = 8'h0a;
   localparam logic [7:0] VEC_LINE_F      = 8'h0b;
   localparam logic [7:0] VEC_COPROC_PROT = 8'h0d;
   localparam logic [7:0] VEC_FORMAT      = 8'h0e;
   localparam logic [7:0] VEC_UNINIT_INT  = 8'h0f;
   localparam logic [7:0] VEC_SPURIOUS    = 8'h18;
   localparam logic [7:0] VEC_AUTO_BASE   = 8'h18;
   localparam logic [7:0] VEC_TRAP_BASE   = 8'h20;
   localparam logic [7:0] VEC_FLOAT_BASE  = 8'h30;
   localparam logic [7:0] VEC_PAGING_BASE = 8'h38;
   localparam logic [7:0] VEC_USER_BASE   = 8'h40;
   // cause codes presented to the mapper
   localparam logic [4:0] CS_RESET_SSP = 5'h00;
   localparam logic [4:0] CS_RESET_PC  = 5'h01;
   localparam logic [4:0] CS_BUS_ERR   = 5'h02;
   localparam logic [4:0] CS_ADDR_ERR  = 5'h03;
   localparam logic [4:0] CS_ILLEGAL   = 5'h04;
   localparam logic [4:0] CS_ZERO_DIV  = 5'h05;
   localparam logic [4:0] CS_BOUNDS    = 5'h06;
   localparam logic [4:0] CS_COND_TRAP = 5'h07;
   localparam logic [4:0] CS_PRIV      = 5'h08;
   localparam logic [4:0] CS_TRACE     = 5'h09;
   localparam logic [4:0] CS_LINE_A    = 5'h0a;
   localparam logic [4:0] CS_LINE_F    = 5'h0b;
   localparam logic [4:0] CS_COPROC    = 5'h0c;
   localparam logic [4:0] CS_FORMAT    = 5'h0d;
   localparam logic [4:0] CS_UNINIT    = 5'h0e;
   localparam logic [4:0] CS_SPURIOUS  = 5'h0f;
   localparam logic [4:0] CS_AUTOVEC   = 5'h10;
   localparam logic [4:0] CS_TRAP      = 5'h11;
   localparam logic [4:0] CS_FLOAT     = 5'h12;
   localparam logic [4:0] CS_PAGING    = 5'h13;
   localparam logic [4:0] CS_USER      = 5'h14;
   // address spaces on the function code lines
   localparam logic [2:0] FC_SUP_DATA = 3'h5;
   localparam logic [2:0] FC_SUP_PROG = 3'h6;
   // status word fields
   localparam int SW_TRACE_HI = 15;
   localparam int SW_TRACE_LO = 14;
   localparam int SW_SUPER    = 13;
   // fault frame format codes
   localparam logic [3:0] FMT_SHORT = 4'ha;
   localparam logic [3:0] FMT_LONG  = 4'hb;
   // stacking: words pushed per frame kind
   localparam logic [4:0] WORDS_SHORT = 5'h08;
   localparam logic [4:0] WORDS_LONG  = 5'h16;
   localparam logic [31:0] STACK_STEP = 32'h0000_0004;
   // stacked word selectors
   localparam logic [4:0] SLOT_FMT_VO = 5'h00;
   localparam logic [4:0] SLOT_PC     = 5'h01;
   localparam logic [4:0] SLOT_SW     = 5'h02;
   // machine states
   typedef enum logic [4:0] {
      BFEV_IDLE  = 5'b00001,
      BFEV_WAIT  = 5'b00010,
      BFEV_ENTER = 5'b00100,
      BFEV_STACK = 5'b01000,
      BFEV_HALT  = 5'b10000
   } bfev_state_t;
endpackage

//--- logic/bfev_vec_map.sv
// maps an exception cause to vector number, table offset and fetch space
module bfev_vec_map (
   // cause
   input  wire logic [4:0]  i_cause,
   input  wire logic [3:0]  i_index,
   input  wire logic [7:0]  i_user_vec,
   // result
   output logic      [7:0]  o_vector,
   output logic      [9:0]  o_offset,
   output logic      [2:0]  o_space
);
   function automatic logic [7:0] vec_of(input logic [4:0] c, input logic [3:0] k, input logic [7:0] u);
      case (c)
         bfev_pkg::CS_RESET_SSP: vec_of = bfev_pkg::VEC_RESET_SSP;
         bfev_pkg::CS_RESET_PC:  vec_of = bfev_pkg::VEC_RESET_PC;
         bfev_pkg::CS_BUS_ERR:   vec_of = bfev_pkg::VEC_BUS_ERR;
         bfev_pkg::CS_ADDR_ERR:  vec_of = bfev_pkg::VEC_ADDR_ERR;
         bfev_pkg::CS_ILLEGAL:   vec_of = bfev_pkg::VEC_ILLEGAL;
         bfev_pkg::CS_ZERO_DIV:  vec_of = bfev_pkg::VEC_ZERO_DIV;
         bfev_pkg::CS_BOUNDS:    vec_of = bfev_pkg::VEC_BOUNDS;
         bfev_pkg::CS_COND_TRAP: vec_of = bfev_pkg::VEC_COND_TRAP;
         bfev_pkg::CS_PRIV:      vec_of = bfev_pkg::VEC_PRIV;
         bfev_pkg::CS_TRACE:     vec_of = bfev_pkg::VEC_TRACE;
         bfev_pkg::CS_LINE_A:    vec_of = bfev_pkg::VEC_LINE_A;
         bfev_pkg::CS_LINE_F:    vec_of = bfev_pkg::VEC_LINE_F;
         bfev_pkg::CS_COPROC:    vec_of = bfev_pkg::VEC_COPROC_PROT;
         bfev_pkg::CS_FORMAT:    vec_of = bfev_pkg::VEC_FORMAT;
         bfev_pkg::CS_UNINIT:    vec_of = bfev_pkg::VEC_UNINIT_INT;
         bfev_pkg::CS_SPURIOUS:  vec_of = bfev_pkg::VEC_SPURIOUS;
         // level 1..7 lands on 25..31; level 0 is not an interrupt
         bfev_pkg::CS_AUTOVEC:   vec_of = bfev_pkg::VEC_AUTO_BASE + {5'h00, k[2:0]};
         bfev_pkg::CS_TRAP:      vec_of = bfev_pkg::VEC_TRAP_BASE + {4'h0, k};
         bfev_pkg::CS_FLOAT:     vec_of = (k[2:0] == 3'h7) ? bfev_pkg::VEC_FLOAT_BASE
                                          : bfev_pkg::VEC_FLOAT_BASE + {5'h00, k[2:0]};
         bfev_pkg::CS_PAGING:    vec_of = (k[1:0] == 2'h3) ? bfev_pkg::VEC_PAGING_BASE
                                          : bfev_pkg::VEC_PAGING_BASE + {6'h00, k[1:0]};
         // reserved numbers below 64 pushed into user range
         bfev_pkg::CS_USER:      vec_of = (u < bfev_pkg::VEC_USER_BASE) ? bfev_pkg::VEC_USER_BASE : u;
         default:                vec_of = bfev_pkg::VEC_FORMAT;
      endcase
   endfunction

   logic [7:0] vec_w;
   assign vec_w    = vec_of(i_cause, i_index, i_user_vec);
   assign o_vector = vec_w;
   assign o_offset = {vec_w, 2'b00};
   assign o_space  = (vec_w == bfev_pkg::VEC_RESET_SSP || vec_w == bfev_pkg::VEC_RESET_PC)
                     ? bfev_pkg::FC_SUP_PROG : bfev_pkg::FC_SUP_DATA;
endmodule

//--- logic/bfev_core.sv
// exception entry, fault frame stacking and double fault halt
// Notes on behaviour
// - vectors 0,1 give reset stack and pc from supervisor program space
// - bus error yields vector 2, offset 008
// - address error yields vector 3, same entry, short or long frame
// - on entry copy status word, set supervisor, clear both trace bits
// - push vector offset, pc, saved status and internal state on supervisor stack
// - stacked pc is the instruction executing when the fault was detected
// - boundary fault gives short frame, mid-instruction gives long; format code differs
// - bus error during fault, reset or state reload halts the device
// - halted device writes no memory; only external reset restarts it
// - odd prefetch address raises address error with no bus cycle
// - address error during fault or reset processing is a double fault
// - external bus error takes effect only when the bus cycle ends
// - sync no-operation stalls execution until pending bus cycles finish
// - autovectors 25..31, spurious 24, uninitialized 15
// - trap instructions 0..15 use vectors 32..47
// - fixed vectors 4..11, 13, 14 for the listed instruction faults
// - float coprocessor 48..54, paging unit 56..58
// - 64..255 user defined; 12, 16..23, 55, 59..63 reserved
module bfev_core (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_resetn,
   input  wire logic        i_ce,
   // external bus
   input  wire logic        i_bus_fault_input_n,
   input  wire logic        i_cycle_end,
   input  wire logic        i_bus_busy,
   // execution unit
   input  wire logic        i_prefetch_req,
   input  wire logic [31:0] i_prefetch_addr,
   input  wire logic        i_exc_req,
   input  wire logic [4:0]  i_exc_cause,
   input  wire logic [3:0]  i_exc_index,
   input  wire logic [7:0]  i_user_vec,
   input  wire logic        i_reset_proc,
   input  wire logic        i_reload_active,
   input  wire logic        i_sync_no_operation,
   input  wire logic        i_at_boundary,
   input  wire logic [31:0] i_exec_pc,
   input  wire logic [15:0] i_status_word,
   input  wire logic [31:0] i_ssp,
   input  wire logic [31:0] i_table_base,
   input  wire logic [31:0] i_internal_word,
   input  wire logic        i_push_ack,
   // outputs
   output logic             o_prefetch_go,
   output logic             o_exec_stall,
   output logic             o_entry,
   output logic [7:0]       o_vector,
   output logic [9:0]       o_vec_offset,
   output logic [31:0]      o_vec_fetch_addr,
   output logic [2:0]       o_vec_space,
   output logic [15:0]      o_status_word,
   output logic             o_push_valid,
   output logic [31:0]      o_push_addr,
   output logic [31:0]      o_push_data,
   output logic [4:0]       o_push_slot,
   output logic [3:0]       o_frame_format,
   output logic             o_halted
);
   bfev_pkg::bfev_state_t state_r, state_nxt;

   // pin synchroniser for the bus fault line
   logic       fault_s1_r, fault_s2_r, fault_s3_r, fault_rise_w;
   logic       fault_hold_r;
   logic [4:0] cause_r;
   logic [3:0] index_r;
   logic [7:0] user_r;
   logic [31:0] pc_r;
   logic [15:0] sw_copy_r;
   logic        long_r;
   logic [4:0]  slot_r;
   logic [7:0]  vec_w;
   logic [9:0]  off_w;
   logic [2:0]  space_w;

   logic        odd_fetch_w, fault_now_w, in_fault_w, double_w;
   logic        fault_taken_w, addr_taken_w, take_w, exc_take_w;
   logic        last_slot_w;
   logic [31:0] fetch_addr_w;
   logic [31:0] push_data_w;
   logic [15:0] sw_new_w;

   function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] v);
      vec_addr = base + {22'h000000, v, 2'b00};
   endfunction

   bfev_vec_map u_map (
      .i_cause    (cause_r),
      .i_index    (index_r),
      .i_user_vec (user_r),
      .o_vector   (vec_w),
      .o_offset   (off_w),
      .o_space    (space_w)
   );

   assign odd_fetch_w  = i_prefetch_req && i_prefetch_addr[0];
   // fault only counts at cycle end
   // only a fresh assertion arms the hold, so a line still high after its cycle cannot re-fire
   assign fault_rise_w = fault_s2_r && !fault_s3_r;
   assign fault_now_w  = (fault_rise_w || fault_hold_r) && i_cycle_end;
   assign in_fault_w   = (state_r == bfev_pkg::BFEV_ENTER) || (state_r == bfev_pkg::BFEV_STACK)
                         || i_reset_proc;
   // bus error during fault, reset or reload
   // address error during fault or reset, not reload
   assign double_w     = (fault_now_w && (in_fault_w || i_reload_active))
                         || (odd_fetch_w && in_fault_w);
   assign fault_taken_w = fault_now_w && !double_w;
   assign addr_taken_w  = odd_fetch_w && !double_w && !fault_taken_w;
   assign exc_take_w    = i_exc_req && !fault_now_w && !odd_fetch_w;
   assign take_w        = (state_r == bfev_pkg::BFEV_IDLE || state_r == bfev_pkg::BFEV_WAIT)
                          && (fault_taken_w || addr_taken_w || exc_take_w);
   assign sw_new_w = (i_status_word | (16'h0001 << bfev_pkg::SW_SUPER))
                     & ~((16'h0001 << bfev_pkg::SW_TRACE_HI) | (16'h0001 << bfev_pkg::SW_TRACE_LO));
   assign fetch_addr_w = vec_addr(i_table_base, vec_w);
   assign last_slot_w  = slot_r == ((long_r ? bfev_pkg::WORDS_LONG : bfev_pkg::WORDS_SHORT) - 5'h01);

   always_comb begin
      case (slot_r)
         bfev_pkg::SLOT_FMT_VO: push_data_w = {16'h0000,
                                               long_r ? bfev_pkg::FMT_LONG : bfev_pkg::FMT_SHORT,
                                               2'b00, off_w};
         bfev_pkg::SLOT_PC:     push_data_w = pc_r;
         bfev_pkg::SLOT_SW:     push_data_w = {16'h0000, sw_copy_r};
         default:               push_data_w = i_internal_word;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         bfev_pkg::BFEV_IDLE: begin
            if (double_w)
               state_nxt = bfev_pkg::BFEV_HALT;
            else if (take_w)
               state_nxt = bfev_pkg::BFEV_ENTER;
            else if (i_sync_no_operation && i_bus_busy)
               state_nxt = bfev_pkg::BFEV_WAIT;
         end
         bfev_pkg::BFEV_WAIT: begin
            if (double_w)
               state_nxt = bfev_pkg::BFEV_HALT;
            else if (take_w)
               state_nxt = bfev_pkg::BFEV_ENTER;
            else if (!i_bus_busy)
               state_nxt = bfev_pkg::BFEV_IDLE;
         end
         bfev_pkg::BFEV_ENTER: begin
            if (double_w)
               state_nxt = bfev_pkg::BFEV_HALT;
            else
               state_nxt = bfev_pkg::BFEV_STACK;
         end
         bfev_pkg::BFEV_STACK: begin
            if (double_w)
               state_nxt = bfev_pkg::BFEV_HALT;
            else if (i_push_ack && last_slot_w)
               state_nxt = bfev_pkg::BFEV_IDLE;
         end
         bfev_pkg::BFEV_HALT: state_nxt = bfev_pkg::BFEV_HALT;
         default:             state_nxt = bfev_pkg::BFEV_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         fault_s1_r <= 1'b0;
         fault_s2_r <= 1'b0;
         fault_s3_r <= 1'b0;
      end else if (i_ce) begin
         fault_s1_r <= !i_bus_fault_input_n;
         fault_s2_r <= fault_s1_r;
         fault_s3_r <= fault_s2_r;
      end
   end

   // an asserted fault line is held until the cycle ends
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn)
         fault_hold_r <= 1'b0;
      else if (i_ce)
         fault_hold_r <= (fault_hold_r || fault_rise_w) && !i_cycle_end;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn)
         state_r <= bfev_pkg::BFEV_IDLE;
      else if (i_ce)
         state_r <= state_nxt;
   end

   // capture of cause, pc and status on entry
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         cause_r   <= bfev_pkg::CS_RESET_SSP;
         index_r   <= 4'h0;
         user_r    <= bfev_pkg::VEC_USER_BASE;
         pc_r      <= 32'h0000_0000;
         sw_copy_r <= 16'h0000;
         long_r    <= 1'b0;
      end else if (i_ce && take_w && !double_w) begin
         cause_r   <= fault_taken_w ? bfev_pkg::CS_BUS_ERR
                      : addr_taken_w ? bfev_pkg::CS_ADDR_ERR : i_exc_cause;
         index_r   <= i_exc_index;
         user_r    <= i_user_vec;
         pc_r      <= i_exec_pc;
         sw_copy_r <= i_status_word;
         long_r    <= (fault_taken_w || addr_taken_w) && !i_at_boundary;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn)
         slot_r <= 5'h00;
      else if (i_ce) begin
         if (state_r == bfev_pkg::BFEV_ENTER)
            slot_r <= 5'h00;
         // back to slot 0 at frame end so entry shows the first slot
         else if (state_r == bfev_pkg::BFEV_STACK && i_push_ack)
            slot_r <= last_slot_w ? 5'h00 : slot_r + 5'h01;
      end
   end

   // registered outputs
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_prefetch_go    <= 1'b0;
         o_exec_stall     <= 1'b0;
         o_entry          <= 1'b0;
         o_vector         <= 8'h00;
         o_vec_offset     <= 10'h000;
         o_vec_fetch_addr <= 32'h0000_0000;
         o_vec_space      <= bfev_pkg::FC_SUP_PROG;
         o_status_word    <= 16'h0000;
         o_push_valid     <= 1'b0;
         o_push_addr      <= 32'h0000_0000;
         o_push_data      <= 32'h0000_0000;
         o_push_slot      <= 5'h00;
         o_frame_format   <= bfev_pkg::FMT_SHORT;
         o_halted         <= 1'b0;
      end else if (i_ce) begin
         o_prefetch_go    <= i_prefetch_req && !i_prefetch_addr[0] && state_nxt == bfev_pkg::BFEV_IDLE;
         o_exec_stall     <= state_nxt != bfev_pkg::BFEV_IDLE;
         o_entry          <= state_r == bfev_pkg::BFEV_ENTER && state_nxt == bfev_pkg::BFEV_STACK;
         o_vector         <= vec_w;
         o_vec_offset     <= off_w;
         o_vec_fetch_addr <= fetch_addr_w;
         o_vec_space      <= space_w;
         if (take_w && !double_w)
            o_status_word <= sw_new_w;
         o_push_valid     <= state_nxt == bfev_pkg::BFEV_STACK;
         o_push_addr      <= i_ssp - ({27'h0000000, slot_r} + 32'h0000_0001) * bfev_pkg::STACK_STEP;
         o_push_data      <= push_data_w;
         o_push_slot      <= slot_r;
         o_frame_format   <= long_r ? bfev_pkg::FMT_LONG : bfev_pkg::FMT_SHORT;
         o_halted         <= state_nxt == bfev_pkg::BFEV_HALT;
      end
   end
endmodule

//--- sim/bfev_core_properties.sv
// concurrent checks on the exception vectoring core ports
module bfev_core_properties (
   // clock and reset
   input wire logic        i_clk_sys,
   input wire logic        i_resetn,
   // watched inputs
   input wire logic        i_ce,
   input wire logic        i_bus_busy,
   input wire logic        i_sync_no_operation,
   input wire logic [31:0] i_prefetch_addr,
   input wire logic [31:0] i_table_base,
   input wire logic        i_push_ack,
   // watched outputs
   input wire logic        o_prefetch_go,
   input wire logic        o_exec_stall,
   input wire logic        o_entry,
   input wire logic [7:0]  o_vector,
   input wire logic [9:0]  o_vec_offset,
   input wire logic [31:0] o_vec_fetch_addr,
   input wire logic [15:0] o_status_word,
   input wire logic        o_push_valid,
   input wire logic [4:0]  o_push_slot,
   input wire logic        o_halted
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);
   a_offset_times_four: assert property (o_entry |-> o_vec_offset == {o_vector, 2'b00})
      else $error("vector offset mismatch");
   a_fetch_addr_sum: assert property (o_entry |-> o_vec_fetch_addr == i_table_base + {o_vector, 2'b00})
      else $error("vector fetch address mismatch");
   a_entry_super_set: assert property (o_entry |-> o_status_word[bfev_pkg::SW_SUPER]
      && !o_status_word[bfev_pkg::SW_TRACE_HI] && !o_status_word[bfev_pkg::SW_TRACE_LO])
      else $error("status word not switched to supervisor");
   a_entry_first_slot: assert property (o_entry |-> o_push_valid && o_push_slot == bfev_pkg::SLOT_FMT_VO)
      else $error("entry without first stack slot");
   a_push_slot_hold: assert property (o_push_valid && !i_push_ack && !$past(i_push_ack) |=> o_halted
      || (o_push_valid && $stable(o_push_slot)))
      else $error("push dropped or moved without ack");
   a_halt_sticky: assert property (o_halted |=> o_halted)
      else $error("halt left without reset");
   a_halt_no_push: assert property (o_halted |-> !o_push_valid && !o_entry)
      else $error("halted core still stacking");
   a_sync_stall: assert property (i_ce && i_sync_no_operation && i_bus_busy |=> o_exec_stall)
      else $error("no stall with bus cycles pending");
   a_prefetch_even: assert property (o_prefetch_go |-> !$past(i_prefetch_addr[0]))
      else $error("bus cycle for odd prefetch");
   c_bus_fault: cover property (o_entry && o_vector == 8'h02);
   c_halt: cover property ($rose(o_halted));
   c_stall: cover property (i_sync_no_operation && o_exec_stall);
endmodule

//--- sim/bfev_bus_model.sv
// external bus logic model: bus cycles with optional fault, push acknowledge
module bfev_bus_model (
   // clock
   input  wire logic i_clk_sys,
   // stack push handshake
   input  wire logic i_push_valid,
   output logic      o_push_ack,
   // bus cycle signals
   output logic      o_bus_fault_input_n,
   output logic      o_cycle_end,
   output logic      o_bus_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned ack_wait = 1;
   initial begin
      {o_push_ack, o_cycle_end, o_bus_busy} = 3'h0;
      o_bus_fault_input_n = 1'b1;
   end
   task automatic run_cycle(input int len, input logic fault);
      @(posedge i_clk_sys);
      #1;
      {o_bus_busy, o_bus_fault_input_n} = {1'b1, !fault};
      repeat (len) @(posedge i_clk_sys);
      #1;
      o_cycle_end = 1'b1;
      @(posedge i_clk_sys);
      #1;
      // released fault line returns to its pull-up
      {o_cycle_end, o_bus_busy, o_bus_fault_input_n} = 3'b001;
   endtask
   // ack after 1..3 cycles: stack data lags the slot, so never on the first edge
   always @(posedge i_clk_sys) begin
      #1;
      if (o_push_ack || !i_push_valid) begin
         o_push_ack = 1'b0;
         ack_wait = $urandom_range(3, 1);
      end else if (ack_wait != 0) ack_wait--;
      else o_push_ack = 1'b1;
   end
endmodule

//--- sim/bfev_core_tb.sv
// self-checking bench for the exception vectoring core
module bfev_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk_sys = 1'b0, i_resetn = 1'b0, i_ce = 1'b1, i_prefetch_req = 1'b0, i_exc_req = 1'b0;
   logic        i_reset_proc = 1'b0, i_reload_active = 1'b0, i_sync_no_operation = 1'b0, i_at_boundary = 1'b1;
   logic [31:0] i_prefetch_addr = 32'h0, i_exec_pc = 32'h0, i_ssp = 32'h1000, i_table_base = 32'h0;
   logic [31:0] i_internal_word = 32'h0, o_vec_fetch_addr, o_push_addr, o_push_data, e_addr;
   logic [15:0] i_status_word = 16'h0, o_status_word, e_sw;
   logic [4:0]  i_exc_cause = 5'h0, o_push_slot, cs;
   logic [3:0]  i_exc_index = 4'h0, o_frame_format, e_fmt;
   logic [7:0]  i_user_vec = 8'h40, o_vector, e_vec;
   logic [9:0]  o_vec_offset, e_off;
   logic [2:0]  o_vec_space, e_space;
   logic        i_bus_fault_input_n, i_cycle_end, i_bus_busy, i_push_ack, seen_entry = 1'b0, go_seen = 1'b0;
   logic        o_prefetch_go, o_exec_stall, o_entry, o_push_valid, o_halted;
   logic [31:0] words [0:31];
   int          n_fail = 0, comparisons = 0, n_words = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   bfev_bus_model bus_u (.i_clk_sys, .i_push_valid(o_push_valid), .o_push_ack(i_push_ack),
      .o_bus_fault_input_n(i_bus_fault_input_n), .o_cycle_end(i_cycle_end), .o_bus_busy(i_bus_busy));
   bfev_core dut_u (.i_clk_sys, .i_resetn, .i_ce, .i_bus_fault_input_n, .i_cycle_end, .i_bus_busy,
      .i_prefetch_req, .i_prefetch_addr, .i_exc_req, .i_exc_cause, .i_exc_index, .i_user_vec, .i_reset_proc,
      .i_reload_active, .i_sync_no_operation, .i_at_boundary, .i_exec_pc, .i_status_word, .i_ssp, .i_table_base,
      .i_internal_word, .i_push_ack, .o_prefetch_go, .o_exec_stall, .o_entry, .o_vector, .o_vec_offset,
      .o_vec_fetch_addr, .o_vec_space, .o_status_word, .o_push_valid, .o_push_addr, .o_push_data, .o_push_slot,
      .o_frame_format, .o_halted);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      if (o_entry === 1'b1) begin
         seen_entry = 1'b1;
         {e_vec, e_off, e_addr, e_space, e_sw, e_fmt} =
            {o_vector, o_vec_offset, o_vec_fetch_addr, o_vec_space, o_status_word, o_frame_format};
      end
      if (o_prefetch_go === 1'b1) go_seen = 1'b1;
      if (o_push_valid === 1'b1 && i_push_ack === 1'b1) begin
         words[o_push_slot] = o_push_data;
         n_words++;
         check(o_push_addr, i_ssp - {o_push_slot, 2'b00} - 32'h4);
      end
   end
   function automatic logic [7:0] exp_vec(input logic [4:0] c, input logic [3:0] x, input logic [7:0] u);
      case (c)
         bfev_pkg::CS_COPROC: return 8'h0d;
         bfev_pkg::CS_FORMAT: return 8'h0e;
         bfev_pkg::CS_UNINIT: return 8'h0f;
         bfev_pkg::CS_SPURIOUS: return 8'h18;
         bfev_pkg::CS_AUTOVEC: return 8'h18 + x;
         bfev_pkg::CS_TRAP: return 8'h20 + x;
         bfev_pkg::CS_FLOAT: return 8'h30 + x;
         bfev_pkg::CS_PAGING: return 8'h38 + x;
         bfev_pkg::CS_USER: return u;
         default: return {3'h0, c};
      endcase
   endfunction
   function automatic logic [3:0] idx(input logic [4:0] c);
      case (c)
         bfev_pkg::CS_AUTOVEC: return 4'($urandom_range(7, 1));
         bfev_pkg::CS_FLOAT: return 4'($urandom_range(6));
         bfev_pkg::CS_PAGING: return 4'($urandom_range(2));
         default: return 4'($urandom);
      endcase
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic do_reset();
      i_resetn = 1'b0;
      tick(8);
      i_resetn = 1'b1;
      tick(1);
   endtask
   task automatic wait_done();
      int k;
      k = 0;
      while (k < 300 && !(seen_entry && o_push_valid === 1'b0)) begin
         tick(1);
         k++;
      end
      check(k < 300, 1'b1);
      tick(2);
   endtask
   task automatic prep(input logic bnd);
      {i_at_boundary, i_exec_pc, i_status_word} = {bnd, $urandom & 32'hffff_fffe, 16'($urandom)};
      {i_ssp, i_internal_word} = {($urandom & 32'h00ff_fff0) | 32'h1000, $urandom};
      {i_table_base, i_user_vec} = {$urandom & 32'hffff_fc00, 8'($urandom_range(255, 64))};
      {seen_entry, go_seen, n_words} = {1'b0, 1'b0, 32'h0};
      tick(2);
   endtask
   task automatic odd_fetch();
      {i_prefetch_addr, i_prefetch_req} = {$urandom | 32'h1, 1'b1};
      tick(1);
      i_prefetch_req = 1'b0;
   endtask
   task automatic raise(input logic [4:0] c, input logic [3:0] x);
      logic [7:0] v;
      prep(1'($urandom));
      v = exp_vec(c, x, i_user_vec);
      {i_exc_cause, i_exc_index, i_exc_req} = {c, x, 1'b1};
      tick(1);
      i_exc_req = 1'b0;
      wait_done();
      check(e_vec, v);
      check(e_off, {v, 2'b00});
      check(e_space, (v < 8'h02) ? 3'h6 : 3'h5);
      check(e_addr, i_table_base + {v, 2'b00});
   endtask
   task automatic fault(input logic bnd);
      prep(bnd);
      bus_u.run_cycle($urandom_range(9, 3), 1'b1);
      check(seen_entry, 1'b0);
      wait_done();
      check(e_vec, 8'h02);
      check(n_words, bnd ? 8 : 22);
      check(e_fmt, bnd ? 4'ha : 4'hb);
      check(words[0], {16'h0, bnd ? 4'ha : 4'hb, 12'h008});
      check(e_sw, {3'b001, i_status_word[12:0]});
      check(words[1], i_exec_pc);
      check(words[2], {16'h0, i_status_word});
      check(o_halted, 1'b0);
   endtask
   initial begin
      void'($urandom(32'h8f35));
      do_reset();
      check({o_vec_space, o_frame_format, o_halted, o_push_valid, o_entry}, 10'h350);
      for (int c = 0; c < 50; c++) begin
         cs = 5'(c < 21 ? c : $urandom_range(20));
         raise(cs, idx(cs));
      end
      raise(bfev_pkg::CS_TRAP, 4'hf);
      fault(1'b1);
      fault(1'b0);
      repeat (4) fault(1'($urandom));
      prep(1'b0);
      odd_fetch();
      wait_done();
      check(e_vec, 8'h03);
      check(go_seen, 1'b0);
      check(n_words, 22);
      prep(1'b1);
      {i_prefetch_addr, i_prefetch_req} = {$urandom & 32'hffff_fffe, 1'b1};
      tick(3);
      i_prefetch_req = 1'b0;
      check({go_seen, seen_entry}, 2'b10);
      i_sync_no_operation = 1'b1;
      fork
         bus_u.run_cycle(8, 1'b0);
         begin
            tick(5);
            check(o_exec_stall, 1'b1);
         end
      join
      tick(3);
      check(o_exec_stall, 1'b0);
      i_sync_no_operation = 1'b0;
      // modes: fault in stacking, odd fetch in stacking, reload, reset with fault, reset with odd fetch
      for (int m = 0; m < 5; m++) begin
         prep(1'b0);
         {i_reload_active, i_reset_proc} = {m == 2, m > 2};
         if (m < 2) odd_fetch();
         tick(3);
         if (m == 1 || m == 4) odd_fetch();
         else bus_u.run_cycle(4, 1'b1);
         tick(4);
         check(o_halted, 1'b1);
         {i_reload_active, i_reset_proc, n_words} = {1'b0, 1'b0, 32'h0};
         odd_fetch();
         i_exc_req = 1'b1;
         tick(20);
         i_exc_req = 1'b0;
         check({o_halted, n_words[4:0]}, 6'h20);
         do_reset();
         check(o_halted, 1'b0);
      end
      results();
   end
   initial begin
      #300000;
      n_fail++;
      results();
   end
endmodule
bind bfev_core bfev_core_properties chk_u (.i_clk_sys, .i_resetn, .i_ce, .i_bus_busy, .i_sync_no_operation,
   .i_prefetch_addr, .i_table_base, .i_push_ack, .o_prefetch_go, .o_exec_stall, .o_entry, .o_vector,
   .o_vec_offset, .o_vec_fetch_addr, .o_status_word, .o_push_valid, .o_push_slot, .o_halted);
